// ### verilog/dot_trip_top.sv
// dual overspeed trip logic top: pins, channels, registers, interrupt
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module dot_trip_top #(
  parameter int unsigned DB_CYC = dot_pkg::DEBOUNCE_CYC,
  parameter int LIM_W = dot_pkg::LIM_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdData,
  // field pins, active as printed
  input wire logic [1:0] speedPickupInput,
  input wire logic [1:0] testSelect,
  input wire logic testActivate,
  input wire logic resetIn,
  input wire logic failOverrideN,
  // indication outputs, active low
  output logic [1:0] inputFailN,
  output logic [1:0] overspeedN,
  output logic [1:0] overspeedLogicN,
  // companion module lines, active low
  output logic alarmBusN,
  output logic shutdownN,
  // lamps, active high
  output logic ch1InputFailLamp,
  output logic ch2InputFailLamp,
  output logic ch1OverspeedLamp,
  output logic ch2OverspeedLamp,
  // interrupt
  output logic irq
);
  logic [LIM_W-1:0] ovrLim_ff [2];
  logic [LIM_W-1:0] failLim_ff [2];
  logic [LIM_W-1:0] testHalf_ff;
  logic [dot_pkg::IRQ_W-1:0] irqMask_ff;
  logic [dot_pkg::IRQ_W-1:0] irqStat_ff;
  logic [dot_pkg::IRQ_W-1:0] irqEvt;
  logic [1:0] pickupLvl;
  logic [1:0] selLvl;
  logic actLvl;
  logic ovrLvl;
  logic rstLvl;
  logic rstLvlD_ff;
  logic clrPulse;
  logic [1:0] overLat;
  logic [1:0] failLat;
  logic [1:0] testOn;
  logic [1:0] setOver;
  logic [1:0] setFail;
  logic [1:0] overLatD_ff;
  logic [1:0] failLatD_ff;
  logic fault;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  // shared pins: one filter each
  dot_debounce #(.STABLE(DB_CYC)) uAct (
    .mclk(mclk),
    .reset(reset),
    .pin(testActivate),
    .level(actLvl)
  );
  dot_debounce #(.STABLE(DB_CYC)) uOvr (
    .mclk(mclk),
    .reset(reset),
    .pin(failOverrideN),
    .level(ovrLvl)
  );
  dot_debounce #(.STABLE(DB_CYC)) uRst (
    .mclk(mclk),
    .reset(reset),
    .pin(resetIn),
    .level(rstLvl)
  );

  always_ff @(posedge mclk) begin
    if (reset) begin
      rstLvlD_ff <= dot_pkg::PIN_IDLE;
    end else begin
      rstLvlD_ff <= rstLvl;
    end
  end
  assign clrPulse = rstLvl & ~rstLvlD_ff;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : gCh
      // the pickup filter must stay at one cycle or it eats the signal
      dot_debounce #(.STABLE(1)) uPick (
        .mclk(mclk),
        .reset(reset),
        .pin(speedPickupInput[ch]),
        .level(pickupLvl[ch])
      );
      dot_debounce #(.STABLE(DB_CYC)) uSel (
        .mclk(mclk),
        .reset(reset),
        .pin(testSelect[ch]),
        .level(selLvl[ch])
      );
      dot_chan #(.LIM_W(LIM_W)) uChan (
        .mclk(mclk),
        .reset(reset),
        .pickup(pickupLvl[ch]),
        .testSel(selLvl[ch]),
        .testAct(actLvl),
        .failOvrN(ovrLvl),
        .clrPulse(clrPulse),
        .ovrLim(ovrLim_ff[ch]),
        .failLim(failLim_ff[ch]),
        .testHalf(testHalf_ff),
        .overLat(overLat[ch]),
        .failLat(failLat[ch]),
        .testOn(testOn[ch]),
        .setOver(setOver[ch]),
        .setFail(setFail[ch])
      );
    end
  endgenerate

  assign fault = (|overLat) | (&failLat);

  // outputs registered so the pins never glitch
  always_ff @(posedge mclk) begin
    if (reset) begin
      inputFailN <= 2'h3;
      overspeedN <= 2'h3;
      overspeedLogicN <= 2'h3;
      alarmBusN <= 1'b1;
      shutdownN <= 1'b1;
    end else begin
      inputFailN <= ~failLat;
      overspeedN <= ~overLat;
      overspeedLogicN <= ~overLat;
      alarmBusN <= ~fault;
      shutdownN <= ~fault;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ch1InputFailLamp <= 1'b0;
      ch2InputFailLamp <= 1'b0;
      ch1OverspeedLamp <= 1'b0;
      ch2OverspeedLamp <= 1'b0;
    end else begin
      ch1InputFailLamp <= failLat[0];
      ch2InputFailLamp <= failLat[1];
      ch1OverspeedLamp <= overLat[0];
      ch2OverspeedLamp <= overLat[1];
    end
  end

  // setpoint registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      ovrLim_ff[0] <= dot_pkg::OVR_LIM_RST;
      ovrLim_ff[1] <= dot_pkg::OVR_LIM_RST;
      failLim_ff[0] <= dot_pkg::FAIL_LIM_RST;
      failLim_ff[1] <= dot_pkg::FAIL_LIM_RST;
      testHalf_ff <= dot_pkg::TEST_HALF_RST;
    end else if (wrStb) begin
      if (hit(addr, dot_pkg::A_OVR_LIM0)) begin
        ovrLim_ff[0] <= wrData[LIM_W-1:0];
      end
      if (hit(addr, dot_pkg::A_OVR_LIM1)) begin
        ovrLim_ff[1] <= wrData[LIM_W-1:0];
      end
      if (hit(addr, dot_pkg::A_FAIL_LIM0)) begin
        failLim_ff[0] <= wrData[LIM_W-1:0];
      end
      if (hit(addr, dot_pkg::A_FAIL_LIM1)) begin
        failLim_ff[1] <= wrData[LIM_W-1:0];
      end
      if (hit(addr, dot_pkg::A_TEST_HALF)) begin
        testHalf_ff <= wrData[LIM_W-1:0];
      end
    end
  end

  // interrupt: new latch sets and each reset command
  assign irqEvt = {clrPulse, failLat & ~failLatD_ff,
                   overLat & ~overLatD_ff};

  always_ff @(posedge mclk) begin
    if (reset) begin
      overLatD_ff <= '0;
      failLatD_ff <= '0;
    end else begin
      overLatD_ff <= overLat;
      failLatD_ff <= failLat;
    end
  end

  // a clear in the same cycle as a new event loses
  always_ff @(posedge mclk) begin
    if (reset) begin
      irqStat_ff <= '0;
    end else if (wrStb && hit(addr, dot_pkg::A_IRQ_STAT)) begin
      irqStat_ff <= (irqStat_ff & ~wrData[dot_pkg::IRQ_W-1:0]) | irqEvt;
    end else begin
      irqStat_ff <= irqStat_ff | irqEvt;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      irqMask_ff <= '0;
    end else if (wrStb && hit(addr, dot_pkg::A_IRQ_MASK)) begin
      irqMask_ff <= wrData[dot_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irqStat_ff & irqMask_ff);

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (reset || !rdStb) begin
      rdData <= '0;
    end else begin
      unique case (1'b1)
        hit(addr, dot_pkg::A_STATUS): begin
          rdData <= 32'({testOn, failLat, overLat});
        end
        hit(addr, dot_pkg::A_IRQ_STAT): rdData <= 32'(irqStat_ff);
        hit(addr, dot_pkg::A_IRQ_MASK): rdData <= 32'(irqMask_ff);
        hit(addr, dot_pkg::A_OVR_LIM0): rdData <= 32'(ovrLim_ff[0]);
        hit(addr, dot_pkg::A_OVR_LIM1): rdData <= 32'(ovrLim_ff[1]);
        hit(addr, dot_pkg::A_FAIL_LIM0): rdData <= 32'(failLim_ff[0]);
        hit(addr, dot_pkg::A_FAIL_LIM1): rdData <= 32'(failLim_ff[1]);
        hit(addr, dot_pkg::A_TEST_HALF): rdData <= 32'(testHalf_ff);
        default: rdData <= '0;
      endcase
    end
  end

  property p_alarm;
    @(posedge mclk) disable iff (reset)
      !$past(reset) |->
      (alarmBusN == !($past(|overLat) || $past(&failLat)));
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm bus does not follow fault");

  property p_shutdown;
    @(posedge mclk) disable iff (reset)
      shutdownN == alarmBusN;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown differs from alarm bus");

  property p_logic_line;
    @(posedge mclk) disable iff (reset)
      (overspeedLogicN == overspeedN) &&
      (ch1OverspeedLamp == !overspeedN[0]);
  endproperty
  a_logic_line: assert property (p_logic_line)
    else $error("overspeed logic line or lamp mismatch");

  property p_hold;
    @(posedge mclk) disable iff (reset)
      overLat[0] && !clrPulse |=> overLat[0];
  endproperty
  a_hold: assert property (p_hold)
    else $error("overspeed latch dropped without reset edge");

  property p_clear;
    @(posedge mclk) disable iff (reset)
      clrPulse && !setFail[1] |=> !failLat[1];
  endproperty
  a_clear: assert property (p_clear)
    else $error("fail latch not cleared by reset edge");

  property p_one_edge;
    @(posedge mclk) disable iff (reset)
      clrPulse |=> !clrPulse [*2];
  endproperty
  a_one_edge: assert property (p_one_edge)
    else $error("reset edge longer than one cycle");

  property p_permit;
    @(posedge mclk) disable iff (reset)
      !actLvl |-> (testOn == 2'h0);
  endproperty
  a_permit: assert property (p_permit)
    else $error("test active without permissive");

  property p_override;
    @(posedge mclk) disable iff (reset)
      $rose(failLat[0]) |-> $past(ovrLvl);
  endproperty
  a_override: assert property (p_override)
    else $error("fail latched while override active");

  property p_irq;
    @(posedge mclk) disable iff (reset)
      $rose(overLat[1]) |=> irqStat_ff[dot_pkg::ST_OVR + 1];
  endproperty
  a_irq: assert property (p_irq)
    else $error("overspeed event not recorded");
endmodule : dot_trip_top
`default_nettype wire

// ### verilog/dot_pkg.sv
// constants shared by the dual overspeed trip logic
package dot_pkg;
  // register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_IRQ_STAT = 8'h04;
  localparam logic [7:0] A_IRQ_MASK = 8'h08;
  localparam logic [7:0] A_OVR_LIM0 = 8'h0c;
  localparam logic [7:0] A_OVR_LIM1 = 8'h10;
  localparam logic [7:0] A_FAIL_LIM0 = 8'h14;
  localparam logic [7:0] A_FAIL_LIM1 = 8'h18;
  localparam logic [7:0] A_TEST_HALF = 8'h1c;
  // setpoints are periods in clock cycles, the test setpoint a half period
  localparam int LIM_W = 24;
  localparam logic [23:0] OVR_LIM_RST = 24'h0061a8;
  localparam logic [23:0] FAIL_LIM_RST = 24'h17b19b;
  localparam logic [23:0] TEST_HALF_RST = 24'h000fa0;
  // status and interrupt bit positions
  localparam int ST_OVR = 0;
  localparam int ST_FAIL = 2;
  localparam int ST_TEST = 4;
  localparam int IRQ_W = 5;
  localparam int IR_RESET = 4;
  // timing
  localparam int CLK_MHZ = 250;
  localparam int DEBOUNCE_US = 1000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  // an open contact reads high
  localparam logic PIN_IDLE = 1'b1;
  typedef enum logic [0:0] {
    MEAS_WAIT = 1'b0,
    MEAS_RUN = 1'b1
  } dot_meas_e;
endpackage : dot_pkg

// ### verilog/dot_debounce.sv
// two-stage synchroniser with stability filter for one pin
`timescale 1ns/1ns
`default_nettype none
module dot_debounce #(
  parameter int unsigned STABLE = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // pin and filtered level
  input wire logic pin,
  output logic level
);
  localparam int CW = $clog2(STABLE + 1);
  logic s1_ff;
  logic s2_ff;
  logic [CW-1:0] cnt_ff;
  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_ff <= dot_pkg::PIN_IDLE;
      s2_ff <= dot_pkg::PIN_IDLE;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_ff <= '0;
      level <= dot_pkg::PIN_IDLE;
    end else if (s2_ff == level) begin
      cnt_ff <= '0;
    end else if (cnt_ff == CW'(STABLE - 1)) begin
      cnt_ff <= '0;
      level <= s2_ff;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
endmodule : dot_debounce
`default_nettype wire

// ### verilog/dot_chan.sv
// one independent speed channel: period measure, compare, latches
`timescale 1ns/1ns
`default_nettype none
module dot_chan #(
  parameter int LIM_W = dot_pkg::LIM_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // filtered pins and the reset edge pulse
  input wire logic pickup,
  input wire logic testSel,
  input wire logic testAct,
  input wire logic failOvrN,
  input wire logic clrPulse,
  // setpoints
  input wire logic [LIM_W-1:0] ovrLim,
  input wire logic [LIM_W-1:0] failLim,
  input wire logic [LIM_W-1:0] testHalf,
  // results
  output logic overLat,
  output logic failLat,
  output logic testOn,
  output logic setOver,
  output logic setFail
);
  dot_pkg::dot_meas_e meas_ff;
  logic [LIM_W-1:0] per_ff;
  logic [LIM_W-1:0] tCnt_ff;
  logic tClk_ff;
  logic src;
  logic srcD_ff;
  logic edgeSeen;
  assign testOn = testSel & testAct;
  assign src = testOn ? tClk_ff : pickup;
  assign edgeSeen = src & ~srcD_ff;
  always_ff @(posedge mclk) begin
    if (reset || !testOn || tCnt_ff + 1'b1 >= testHalf) begin
      tCnt_ff <= '0;
    end else begin
      tCnt_ff <= tCnt_ff + 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      tClk_ff <= 1'b0;
    end else if (testOn && tCnt_ff + 1'b1 >= testHalf) begin
      tClk_ff <= ~tClk_ff;
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      srcD_ff <= 1'b0;
      per_ff <= '0;
      meas_ff <= dot_pkg::MEAS_WAIT;
    end else begin
      srcD_ff <= src;
      if (edgeSeen) begin
        per_ff <= '0;
        meas_ff <= dot_pkg::MEAS_RUN;
      end else if (per_ff != '1) begin
        per_ff <= per_ff + 1'b1;
      end
    end
  end
  assign setOver = (meas_ff == dot_pkg::MEAS_RUN) && edgeSeen &&
                   (per_ff < ovrLim);
  assign setFail = failOvrN && (per_ff > failLim);
  always_ff @(posedge mclk) begin
    if (reset) begin
      overLat <= 1'b0;
      failLat <= 1'b0;
    end else begin
      overLat <= setOver | (overLat & ~clrPulse);
      failLat <= setFail | (failLat & ~clrPulse);
    end
  end
endmodule : dot_chan
`default_nettype wire

// ### verification/dot_pickup_model.sv
// far-side speed pickup source: square wave of programmable half period
`timescale 1ns/1ns
`default_nettype none
module dot_pickup_model (
  // clock
  input wire logic mclk,
  // half period in cycles, zero stops the shaft
  input wire logic [15:0] halfCyc,
  // squared pickup signal
  output logic pickup
);
  logic [15:0] cnt = 16'h0000;
  // one process owns the level, the port only mirrors it
  logic lvl = 1'b0;
  assign pickup = lvl;
  always @(posedge mclk) begin
    if (halfCyc == 16'h0000) begin
      // a stopped shaft holds its level, so the fail timer keeps running
      cnt <= 16'h0000;
    end else if (cnt + 16'h0001 >= halfCyc) begin
      cnt <= 16'h0000;
      lvl <= ~lvl;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule : dot_pickup_model
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the dual overspeed trip logic
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic mclk, reset, wrStb, rdStb, testActivate, resetIn, failOverrideN;
  logic [7:0] addr;
  logic [31:0] wrData, rdData, v;
  logic [1:0] testSelect, inputFailN, overspeedN, overspeedLogicN;
  logic alarmBusN, shutdownN, irq, l0, l1, l2, l3;
  logic [15:0] half0, half1;
  wire [1:0] pick;
  int nFail = 0;
  int nCompared = 0;

  dot_pickup_model u_pick0 (.mclk(mclk), .halfCyc(half0), .pickup(pick[0]));
  dot_pickup_model u_pick1 (.mclk(mclk), .halfCyc(half1), .pickup(pick[1]));
  // short debounce keeps the run brief
  dot_trip_top #(.DB_CYC(4)) u_dut (
    .mclk(mclk), .reset(reset), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .speedPickupInput(pick), .testSelect(testSelect),
    .testActivate(testActivate), .resetIn(resetIn),
    .failOverrideN(failOverrideN), .inputFailN(inputFailN),
    .overspeedN(overspeedN), .overspeedLogicN(overspeedLogicN),
    .alarmBusN(alarmBusN), .shutdownN(shutdownN),
    .ch1InputFailLamp(l0), .ch2InputFailLamp(l1),
    .ch1OverspeedLamp(l2), .ch2OverspeedLamp(l3), .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic finalReport;
    $display("TB: compared %0d failed %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finalReport

  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      nFail++;
      $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chkReg

  // expected pins from latch state: o overspeed, f input failed, i irq
  task automatic chkPins(input logic [1:0] o, input logic [1:0] f,
                         input logic i);
    logic [12:0] exp, got;
    exp = {~f, ~o, ~o, ~(|o | &f), ~(|o | &f), f, o, i};
    got = {inputFailN, overspeedN, overspeedLogicN, alarmBusN, shutdownN,
           l1, l0, l3, l2, irq};
    nCompared++;
    if (got !== exp) begin
      nFail++;
      $display("[ERR] %0t pins got %h exp %h", $time, got, exp);
    end
  endtask : chkPins

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    #1 d = rdData;
  endtask : rd

  task automatic pulseReset;
    @(posedge mclk);
    resetIn <= 1'b0;
    cyc(20);
    @(posedge mclk);
    resetIn <= 1'b1;
    cyc(20);
  endtask : pulseReset

  initial begin
    repeat (30000) @(posedge mclk);
    nFail++;
    finalReport();
  end

  initial begin
    reset = 1'b1;
    addr = 8'h00;
    wrData = 32'h00000000;
    wrStb = 1'b0;
    rdStb = 1'b0;
    testSelect = 2'b00;
    testActivate = 1'b0;
    resetIn = 1'b1;
    failOverrideN = 1'b1;
    half0 = 16'h0000;
    half1 = 16'h0000;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    cyc(20);
    chkPins(2'b00, 2'b00, 1'b0);
    rd(dot_pkg::A_OVR_LIM1, v);
    chkReg(v, {8'h00, dot_pkg::OVR_LIM_RST});
    rd(dot_pkg::A_FAIL_LIM0, v);
    chkReg(v, {8'h00, dot_pkg::FAIL_LIM_RST});
    rd(dot_pkg::A_TEST_HALF, v);
    chkReg(v, {8'h00, dot_pkg::TEST_HALF_RST});
    rd(8'h40, v);
    chkReg(v, 32'h00000000);
    // limits before the shafts turn, else the default trips at once
    // upper byte set on purpose: it must not be stored
    wr(dot_pkg::A_OVR_LIM0, 32'hff000064);
    wr(dot_pkg::A_OVR_LIM1, 32'h00000064);
    wr(dot_pkg::A_FAIL_LIM0, 32'h00000190);
    wr(dot_pkg::A_FAIL_LIM1, 32'h00000190);
    wr(dot_pkg::A_TEST_HALF, 32'h0000000a);
    rd(dot_pkg::A_OVR_LIM0, v);
    chkReg(v, 32'h00000064);
    rd(dot_pkg::A_FAIL_LIM1, v);
    chkReg(v, 32'h00000190);
    half0 <= 16'h0064;
    half1 <= 16'h0064;
    cyc(1000);
    chkPins(2'b00, 2'b00, 1'b0);
    half0 <= 16'h0019;
    cyc(300);
    chkPins(2'b01, 2'b00, 1'b0);
    half0 <= 16'h0064;
    cyc(300);
    chkPins(2'b01, 2'b00, 1'b0);
    rd(dot_pkg::A_STATUS, v);
    chkReg(v, 32'h00000001);
    @(posedge mclk);
    resetIn <= 1'b0;
    @(posedge mclk);
    resetIn <= 1'b1;
    cyc(50);
    chkPins(2'b01, 2'b00, 1'b0);
    pulseReset();
    chkPins(2'b00, 2'b00, 1'b0);
    failOverrideN <= 1'b0;
    half1 <= 16'h0000;
    cyc(1000);
    chkPins(2'b00, 2'b00, 1'b0);
    failOverrideN <= 1'b1;
    cyc(600);
    chkPins(2'b00, 2'b10, 1'b0);
    half0 <= 16'h0000;
    cyc(600);
    chkPins(2'b00, 2'b11, 1'b0);
    half0 <= 16'h0064;
    half1 <= 16'h0064;
    cyc(600);
    pulseReset();
    chkPins(2'b00, 2'b00, 1'b0);
    testSelect <= 2'b01;
    cyc(600);
    chkPins(2'b00, 2'b00, 1'b0);
    testActivate <= 1'b1;
    cyc(300);
    chkPins(2'b01, 2'b00, 1'b0);
    rd(dot_pkg::A_STATUS, v);
    chkReg(v, 32'h00000011);
    testSelect <= 2'b10;
    cyc(300);
    chkPins(2'b11, 2'b00, 1'b0);
    testSelect <= 2'b00;
    testActivate <= 1'b0;
    cyc(100);
    pulseReset();
    chkPins(2'b00, 2'b00, 1'b0);
    rd(dot_pkg::A_IRQ_STAT, v);
    chkReg(v, 32'h0000001f);
    wr(dot_pkg::A_IRQ_MASK, 32'h00000010);
    rd(dot_pkg::A_IRQ_MASK, v);
    chkReg(v, 32'h00000010);
    cyc(2);
    chkPins(2'b00, 2'b00, 1'b1);
    wr(dot_pkg::A_IRQ_STAT, 32'h00000010);
    cyc(2);
    chkPins(2'b00, 2'b00, 1'b0);
    rd(dot_pkg::A_IRQ_STAT, v);
    chkReg(v, 32'h0000000f);
    finalReport();
  end
endmodule : tb_top
`default_nettype wire
